/* verilog/dcsw_core.sv */
// Drive command word interpreter, power-stage state machine and status word
`timescale 1ns/10ps
`include "dcsw_defines.svh"

module dcsw_core
	import dcsw_pkg::*;
(
	input  wire logic        sys_clk,         // System clock, 10 MHz
	input  wire logic        rst,             // Asynchronous reset, active high
	input  wire logic        clk_en,          // Clock enable, freezes state when low
	input  wire logic        cmd_wr,          // Command word write strobe
	input  wire logic [15:0] cmd_wdata,       // Command word write data
	output logic      [15:0] cmd_rdata,       // Command word read back
	output logic      [15:0] status_word,     // Live status word
	input  wire logic        init_done,       // Self test finished
	input  wire logic        fault_present,   // Fault condition active
	input  wire logic        fault_nonfatal,  // Fault reacts with quick stop
	input  wire logic        fault_react_done,// Fault reaction complete
	input  wire logic        qstop_done,      // Quick stop ramp complete
	input  wire logic [15:0] qstop_option,    // Quick stop option code
	input  wire logic        hv_present,      // High voltage at power section
	input  wire logic        warning,         // Warning condition
	input  wire logic        target_reached,  // Mode set-point reached
	input  wire logic        target_changed,  // Software wrote a new target
	input  wire logic        at_rest,         // Drive is stationary
	input  wire logic        int_limit,       // Internal limitation active
	input  wire logic [7:0]  op_mode,         // Active mode of operation
	input  wire logic        mode_flag_a,     // Mode status for bit 12
	input  wire logic        mode_flag_b,     // Mode status for bit 13
	output logic             power_on,        // Power section switched on
	output logic             drive_enable,    // Drive function enabled
	output logic             qstop_run,       // Execute quick stop ramp
	output logic             fault_react_run, // Execute fault reaction
	output logic             halt_req,        // Halt requested
	output logic             ptp_new_target,  // Point to point: new set-point
	output logic             ptp_change_now,  // Point to point: change at once
	output logic             ptp_relative,    // Point to point: relative target
	output logic             home_start,      // Home search start
	output logic             path_enable,     // Interpolated path enable
	output logic             spd_ramp_enable, // Plain speed: ramp enable
	output logic             spd_ramp_unlock, // Plain speed: ramp unlock
	output logic             spd_use_ref      // Plain speed: use reference
);

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [15:0] cmd_word_ff;      // Stored command word
	logic [15:0] nxt_cmd_word;     // Next command word
	dcsw_state_e state_ff;         // Power-stage state
	dcsw_state_e nxt_state;        // Next state
	logic        tgt_ff;           // Target reached indication
	logic        nxt_tgt;          // Next target indication
	logic        fr_prev_ff;       // Fault reset bit last cycle
	logic        nxt_fr_prev;      // Next fault reset history
	logic        qs_from_fault_ff; // Quick stop caused by non-fatal fault
	logic        nxt_qs_from_fault;// Next quick stop cause
	dcsw_cmd_e   cmd;              // Decoded command
	logic        fault_reset;      // Fault reset bit
	logic        qso_stay;         // Option code 5 to 8
	logic        halt_bit;         // Halt bit of command word

	// ********************************************************
	// Command decode
	// ********************************************************
	dcsw_cmd_decode u_decode
	(
		.cmd_word    (cmd_word_ff),
		.cmd         (cmd),
		.fault_reset (fault_reset)
	);

	// Options 5..8 keep the drive in quick stop
	assign qso_stay = (qstop_option >= `DCSW_QSO_STAY_LO) &&
	                  (qstop_option <= `DCSW_QSO_STAY_HI);
	assign halt_bit = cmd_word_ff[`DCSW_CB_HALT];

	// ********************************************************
	// Command word register
	// ********************************************************
	// Reserved bits 9 and 10 are stored as written; the host keeps them zero
	always_comb
	begin
		nxt_cmd_word = cmd_word_ff;
		if (cmd_wr)
			nxt_cmd_word = cmd_wdata;
	end

	// ********************************************************
	// Power-stage state machine
	// ********************************************************
	// Faults take priority over any host command
	always_comb
	begin
		nxt_state = state_ff;
		nxt_qs_from_fault = qs_from_fault_ff;
		nxt_fr_prev = fault_reset;
		if (fault_present && (state_ff != DCSW_S_FRA) && (state_ff != DCSW_S_FAULT))
		begin
			nxt_state = DCSW_S_FRA;
			nxt_qs_from_fault = fault_nonfatal;
		end
		else
		begin
			unique case (state_ff)
				DCSW_S_NRDY:
					if (init_done)
						nxt_state = DCSW_S_SWDIS;
				DCSW_S_SWDIS:
					if (cmd == DCSW_C_SHUTDOWN)
						nxt_state = DCSW_S_RDY;
				DCSW_S_RDY:
					// Switch on with enable op only switches on
					if ((cmd == DCSW_C_DISOP) || (cmd == DCSW_C_ENOP))
						nxt_state = DCSW_S_SWON;
					else if ((cmd == DCSW_C_DISVOLT) || (cmd == DCSW_C_QSTOP))
						nxt_state = DCSW_S_SWDIS;
				DCSW_S_SWON:
					if (cmd == DCSW_C_ENOP)
						nxt_state = DCSW_S_OPEN;
					else if (cmd == DCSW_C_SHUTDOWN)
						nxt_state = DCSW_S_RDY;
					else if ((cmd == DCSW_C_DISVOLT) || (cmd == DCSW_C_QSTOP))
						nxt_state = DCSW_S_SWDIS;
				DCSW_S_OPEN:
					if (cmd == DCSW_C_DISOP)
						nxt_state = DCSW_S_SWON;
					else if (cmd == DCSW_C_SHUTDOWN)
						nxt_state = DCSW_S_RDY;
					else if (cmd == DCSW_C_DISVOLT)
						nxt_state = DCSW_S_SWDIS;
					else if (cmd == DCSW_C_QSTOP)
					begin
						nxt_state = DCSW_S_QSTOP;
						nxt_qs_from_fault = 1'b0;
					end
				DCSW_S_QSTOP:
					if (qso_stay && (cmd == DCSW_C_ENOP))
						nxt_state = DCSW_S_OPEN;
					else if (!qso_stay && (qstop_done || (cmd == DCSW_C_DISVOLT)))
						nxt_state = DCSW_S_SWDIS;
				DCSW_S_FRA:
					if (fault_react_done)
						nxt_state = DCSW_S_FAULT;
				DCSW_S_FAULT:
					// Rising fault reset, and only with the fault gone
					if (fault_reset && !fr_prev_ff && !fault_present)
					begin
						nxt_state = DCSW_S_SWDIS;
						nxt_qs_from_fault = 1'b0;
					end
				default:
					nxt_state = DCSW_S_NRDY;
			endcase
		end
	end

	// ********************************************************
	// Target reached tracking
	// ********************************************************
	// A new target or motion clears the flag unless the set-point is met, or halt or a completed quick stop holds the drive at rest
	always_comb
	begin
		nxt_tgt = tgt_ff;
		if (target_reached)
			nxt_tgt = 1'b1;
		else if ((state_ff == DCSW_S_QSTOP) && qso_stay && qstop_done && at_rest)
			nxt_tgt = 1'b1;
		else if (halt_bit && at_rest)
			nxt_tgt = 1'b1;
		else if (target_changed || !at_rest)
			nxt_tgt = 1'b0;
	end

	// ********************************************************
	// Registers
	// ********************************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_word_ff      <= `DCSW_CMD_RESET;
			state_ff         <= DCSW_S_NRDY;
			tgt_ff           <= 1'b0;
			fr_prev_ff       <= 1'b0;
			qs_from_fault_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			cmd_word_ff      <= nxt_cmd_word;
			state_ff         <= nxt_state;
			tgt_ff           <= nxt_tgt;
			fr_prev_ff       <= nxt_fr_prev;
			qs_from_fault_ff <= nxt_qs_from_fault;
		end
	end

	// ********************************************************
	// Status word
	// ********************************************************
	// Built each cycle from live state, inputs, the registered target flag and the registered quick stop cause; nothing else is latched
	always_comb
	begin
		status_word = 16'h0000;
		unique case (state_ff)
			DCSW_S_NRDY:  status_word[6:0] = 7'h00;
			DCSW_S_SWDIS: status_word[6:0] = 7'h40;
			DCSW_S_RDY:   status_word[6:0] = 7'h21;
			DCSW_S_SWON:  status_word[6:0] = 7'h23;
			DCSW_S_OPEN:  status_word[6:0] = 7'h27;
			DCSW_S_QSTOP: status_word[6:0] = 7'h07;
			DCSW_S_FRA:   status_word[6:0] = 7'h0F;
			DCSW_S_FAULT: status_word[6:0] = 7'h08;
			default:      status_word[6:0] = 7'h00;
		endcase
		// Fault reaction by quick stop: bit 5 clear with 0,1,2 and fault
		if ((state_ff == DCSW_S_FRA) && qs_from_fault_ff)
			status_word[`DCSW_SB_QSTOP] = 1'b0;
		status_word[`DCSW_SB_VOLT]   = hv_present;
		status_word[`DCSW_SB_WARN]   = warning;
		status_word[`DCSW_SB_REMOTE] = 1'b1;
		status_word[`DCSW_SB_TGT]    = tgt_ff;
		status_word[`DCSW_SB_LIMIT]  = int_limit;
		// Bit 12 and 13 only where the mode defines them
		if ((op_mode == `DCSW_OPM_PTP) || (op_mode == `DCSW_OPM_SPP) ||
		    (op_mode == `DCSW_OPM_HOM))
		begin
			status_word[`DCSW_SB_MODE12] = mode_flag_a;
			status_word[`DCSW_SB_MODE13] = mode_flag_b;
		end
		else if (op_mode == `DCSW_OPM_PTH)
			status_word[`DCSW_SB_MODE12] = mode_flag_a;
	end

	// ********************************************************
	// Outputs to the power stage and mode logic
	// ********************************************************
	assign cmd_rdata       = cmd_word_ff;
	assign power_on        = (state_ff == DCSW_S_SWON) || (state_ff == DCSW_S_OPEN) ||
	                         (state_ff == DCSW_S_QSTOP) || (state_ff == DCSW_S_FRA);
	assign drive_enable    = (state_ff == DCSW_S_OPEN) || (state_ff == DCSW_S_QSTOP) ||
	                         (state_ff == DCSW_S_FRA);
	assign qstop_run       = (state_ff == DCSW_S_QSTOP);
	assign fault_react_run = (state_ff == DCSW_S_FRA);
	// Mode bits are qualified by the mode so a stale bit cannot act elsewhere
	assign halt_req        = halt_bit;
	assign ptp_new_target  = (op_mode == `DCSW_OPM_PTP) && cmd_word_ff[`DCSW_CB_MODE4];
	assign ptp_change_now  = (op_mode == `DCSW_OPM_PTP) && cmd_word_ff[`DCSW_CB_MODE5];
	assign ptp_relative    = (op_mode == `DCSW_OPM_PTP) && cmd_word_ff[`DCSW_CB_MODE6];
	assign home_start      = (op_mode == `DCSW_OPM_HOM) && cmd_word_ff[`DCSW_CB_MODE4];
	assign path_enable     = (op_mode == `DCSW_OPM_PTH) && cmd_word_ff[`DCSW_CB_MODE4];
	assign spd_ramp_enable = (op_mode == `DCSW_OPM_SPD) && cmd_word_ff[`DCSW_CB_MODE4];
	assign spd_ramp_unlock = (op_mode == `DCSW_OPM_SPD) && cmd_word_ff[`DCSW_CB_MODE5];
	assign spd_use_ref     = (op_mode == `DCSW_OPM_SPD) && cmd_word_ff[`DCSW_CB_MODE6];

endmodule

/* verilog/dcsw_defines.svh */
// Bit positions, codes and constants of the drive command and status words
`ifndef DCSW_DEFINES_SVH
`define DCSW_DEFINES_SVH

// ********************************************************
// Object indices (informational addresses) and command word reset value
// ********************************************************
`define DCSW_STATUS_INDEX   16'h6041
`define DCSW_COMMAND_INDEX  16'h6040
`define DCSW_CMD_RESET      16'h0000

// ********************************************************
// Command word bit positions
// ********************************************************
`define DCSW_CB_SWITCH_ON   0
`define DCSW_CB_EN_VOLT     1
`define DCSW_CB_QSTOP       2
`define DCSW_CB_EN_OP       3
`define DCSW_CB_MODE4       4
`define DCSW_CB_MODE5       5
`define DCSW_CB_MODE6       6
`define DCSW_CB_FAULT_RST   7
`define DCSW_CB_HALT        8

// ********************************************************
// Status word bit positions
// ********************************************************
`define DCSW_SB_RDY         0
`define DCSW_SB_SWON        1
`define DCSW_SB_OPEN        2
`define DCSW_SB_FAULT       3
`define DCSW_SB_VOLT        4
`define DCSW_SB_QSTOP       5
`define DCSW_SB_SWDIS       6
`define DCSW_SB_WARN        7
`define DCSW_SB_REMOTE      9
`define DCSW_SB_TGT         10
`define DCSW_SB_LIMIT       11
`define DCSW_SB_MODE12      12
`define DCSW_SB_MODE13      13

// ********************************************************
// Mode-of-operation codes and quick-stop option limits
// ********************************************************
`define DCSW_OPM_PTP        8'h01
`define DCSW_OPM_SPP        8'h03
`define DCSW_OPM_FRC        8'h04
`define DCSW_OPM_HOM        8'h06
`define DCSW_OPM_PTH        8'h07
`define DCSW_OPM_SPD        8'h02
`define DCSW_QSO_STAY_LO    16'h0005
`define DCSW_QSO_STAY_HI    16'h0008

`endif

/* verilog/dcsw_pkg.sv */
// Types shared by the drive command and status word logic
package dcsw_pkg;

	// Decoded host commands, one-hot
	typedef enum logic [6:0]
	{
		DCSW_C_NONE     = 7'b0000001,
		DCSW_C_SHUTDOWN = 7'b0000010,
		DCSW_C_SWON     = 7'b0000100,
		DCSW_C_DISVOLT  = 7'b0001000,
		DCSW_C_QSTOP    = 7'b0010000,
		DCSW_C_DISOP    = 7'b0100000,
		DCSW_C_ENOP     = 7'b1000000
	} dcsw_cmd_e;

	// Power-stage states, one-hot
	typedef enum logic [7:0]
	{
		DCSW_S_NRDY  = 8'b00000001,
		DCSW_S_SWDIS = 8'b00000010,
		DCSW_S_RDY   = 8'b00000100,
		DCSW_S_SWON  = 8'b00001000,
		DCSW_S_OPEN  = 8'b00010000,
		DCSW_S_QSTOP = 8'b00100000,
		DCSW_S_FRA   = 8'b01000000,
		DCSW_S_FAULT = 8'b10000000
	} dcsw_state_e;

	typedef logic [15:0] dcsw_word_t;

endpackage

/* verilog/dcsw_cmd_decode.sv */
// Combinational decoder from command word bits to one device command
`timescale 1ns/10ps
`include "dcsw_defines.svh"

module dcsw_cmd_decode
	import dcsw_pkg::*;
(
	input  wire logic      [15:0] cmd_word,    // Command word from host
	output dcsw_cmd_e             cmd,         // Decoded command
	output logic                  fault_reset  // Fault reset bit set
);

	logic so;
	logic ev;
	logic qs;
	logic eo;
	logic fr;

	assign so = cmd_word[`DCSW_CB_SWITCH_ON];
	assign ev = cmd_word[`DCSW_CB_EN_VOLT];
	assign qs = cmd_word[`DCSW_CB_QSTOP];
	assign eo = cmd_word[`DCSW_CB_EN_OP];
	assign fr = cmd_word[`DCSW_CB_FAULT_RST];

	// Fault reset ignores the four other bits
	assign fault_reset = fr;

	// ********************************************************
	// Pattern match; don't-care bits never enter a term
	// ********************************************************
	// Disable voltage is checked first after fault reset since it needs only one zero
	always_comb
	begin
		cmd = DCSW_C_NONE;
		if (fr)
			cmd = DCSW_C_NONE;                               // Fault reset handled apart
		else if (!ev)
			cmd = DCSW_C_DISVOLT;
		else if (!qs)
			cmd = DCSW_C_QSTOP;
		else if (!so)
			cmd = DCSW_C_SHUTDOWN;
		else if (eo)
			cmd = DCSW_C_ENOP;                               // Also switch-on in RDY
		else
			cmd = DCSW_C_DISOP;                              // Also switch-on
	end

endmodule

/* testbench/dcsw_core_sva.sv */
// Concurrent checks on the drive command and status word block
`timescale 1ns/10ps

// ****************************************
// Checker on the top-level ports
// ****************************************
module dcsw_core_chk
	import dcsw_pkg::*;
(
	input wire logic        sys_clk,         // System clock
	input wire logic        rst,             // Asynchronous reset
	input wire logic        clk_en,          // Clock enable
	input wire logic        cmd_wr,          // Command write strobe
	input wire logic [15:0] cmd_wdata,       // Command write data
	input wire logic [15:0] cmd_rdata,       // Stored command word
	input wire logic [15:0] status_word,     // Live status word
	input wire logic        fault_present,   // Fault condition
	input wire logic        hv_present,      // High voltage present
	input wire logic        warning,         // Warning condition
	input wire logic        target_reached,  // Set-point reached
	input wire logic        target_changed,  // New target written
	input wire logic        at_rest,         // Drive stationary
	input wire logic        int_limit,       // Internal limit
	input wire logic [7:0]  op_mode,         // Mode of operation
	input wire logic        mode_flag_a,     // Mode flag for bit 12
	input wire logic        drive_enable,    // Drive enabled
	input wire logic        qstop_run,       // Quick stop running
	input wire logic        halt_req,        // Halt requested
	input wire logic        ptp_new_target,  // Point to point bit 4
	input wire logic        ptp_change_now,  // Point to point bit 5
	input wire logic        ptp_relative     // Point to point bit 6
);
	// One domain, so one clocking and one disable for all
	default clocking dcsw_cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Live status bits follow their inputs with no latching
	chk_remote_const: assert property (status_word[9] && !status_word[8])
		else $error("remote or unused status bit wrong");
	chk_volt_live: assert property (status_word[4] == hv_present)
		else $error("voltage bit does not follow input");
	chk_warn_live: assert property (status_word[7] == warning)
		else $error("warning bit does not follow input");
	chk_limit_live: assert property (status_word[11] == int_limit)
		else $error("limit bit does not follow input");
	chk_qstop_regen: assert property (qstop_run |->
		status_word[2:0] == 3'h7 && !status_word[5])
		else $error("quick stop status pattern wrong");
	chk_path_bits: assert property (op_mode == 8'h07 |->
		status_word[13:12] == {1'b0, mode_flag_a})
		else $error("interpolation status bits wrong");

	// Command bits are stored and reach the halt and mode outputs
	chk_halt_map: assert property (halt_req == cmd_rdata[8])
		else $error("halt output does not follow bit 8");
	chk_ptp_map: assert property (op_mode == 8'h01 |->
		{ptp_relative, ptp_change_now, ptp_new_target} == cmd_rdata[6:4])
		else $error("point to point outputs wrong");
	chk_cmd_store: assert property (cmd_wr && clk_en |=> cmd_rdata == $past(cmd_wdata))
		else $error("command word not stored");

	// Switch on with enable bit set from ready must pass through switched on before operation enabled
	chk_swon_only: assert property ((status_word[6:0] & 7'h6F) == 7'h21 && clk_en && cmd_wr
		&& !cmd_rdata[0] && !fault_present && cmd_wdata[7] == 1'b0 && cmd_wdata[3:0] == 4'hF
		##1 !fault_present |=> !drive_enable)
		else $error("operation enabled straight from ready");

	// Target flag is registered, so it is judged one edge later
	chk_tgt_set: assert property (clk_en && target_reached && at_rest && !target_changed
		|=> status_word[10])
		else $error("target bit not set");
	chk_tgt_clear: assert property (clk_en && !at_rest && !target_reached
		|=> !status_word[10])
		else $error("target bit not cleared");
endmodule

bind dcsw_core dcsw_core_chk i_dcsw_core_chk (.sys_clk, .rst, .clk_en, .cmd_wr, .cmd_wdata,
	.cmd_rdata, .status_word, .fault_present, .hv_present, .warning, .target_reached,
	.target_changed, .at_rest, .int_limit, .op_mode, .mode_flag_a, .drive_enable, .qstop_run,
	.halt_req, .ptp_new_target, .ptp_change_now, .ptp_relative);

/* testbench/dcsw_host_model.sv */
// Host controller model that writes the drive command word
`timescale 1ns/10ps

module dcsw_host_model
(
	input  wire logic        sys_clk,   // System clock
	output logic             cmd_wr,    // Command write strobe
	output logic      [15:0] cmd_wdata  // Command write data
);
	// Idle bus at time zero
	initial
	begin
		cmd_wr = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// One write after an optional idle gap; reserved bits always zero
	task automatic send(input logic [15:0] word, input int gap);
		repeat (gap) @(posedge sys_clk);
		@(posedge sys_clk);
		cmd_wr <= 1'b1;
		cmd_wdata <= word & 16'hF9FF;
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
		// Data no longer qualified, so it shows the inverse, not a stale copy
		cmd_wdata <= ~(word & 16'hF9FF);
	endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the drive command and status word block
`timescale 1ns/10ps

module testbench
	import dcsw_pkg::*;
	;
	// ****************************************
	// Signals
	// ****************************************
	logic        sys_clk = 1'b0;   // 10 MHz clock
	logic        rst = 1'b1;       // Reset, high at start
	logic        clk_en, init_done, fault_present, fault_nonfatal, fault_react_done;
	logic        qstop_done, hv_present, warning, target_reached, target_changed;
	logic        at_rest, int_limit, mode_flag_a, mode_flag_b, cmd_wr;
	logic        power_on, drive_enable, qstop_run, fault_react_run, halt_req;
	logic        ptp_new_target, ptp_change_now, ptp_relative, home_start, path_enable;
	logic        spd_ramp_enable, spd_ramp_unlock, spd_use_ref;
	logic [15:0] qstop_option, cmd_wdata, cmd_rdata, status_word, w;
	logic [7:0]  op_mode;          // Active mode
	int          fails = 0;        // Mismatch count
	int          checks = 0;       // Comparison count
	int          cyc = 0;          // Timeout counter
	int          i;                // Loop index
	logic [7:0]  modes [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07};
	logic [15:0] walk_w [7] = '{16'h0006, 16'h000F, 16'h000F, 16'h0007, 16'h000F, 16'h000B, 16'h000F};
	logic [6:0]  walk_s [7] = '{7'h21, 7'h23, 7'h27, 7'h23, 7'h27, 7'h07, 7'h07};

	always #50 sys_clk = ~sys_clk;

	dcsw_core i_dcsw_core (.sys_clk, .rst, .clk_en, .cmd_wr, .cmd_wdata, .cmd_rdata, .status_word,
		.init_done, .fault_present, .fault_nonfatal, .fault_react_done, .qstop_done, .qstop_option,
		.hv_present, .warning, .target_reached, .target_changed, .at_rest, .int_limit, .op_mode,
		.mode_flag_a, .mode_flag_b, .power_on, .drive_enable, .qstop_run, .fault_react_run,
		.halt_req, .ptp_new_target, .ptp_change_now, .ptp_relative, .home_start, .path_enable,
		.spd_ramp_enable, .spd_ramp_unlock, .spd_use_ref);
	dcsw_host_model i_dcsw_host_model (.sys_clk, .cmd_wr, .cmd_wdata);

	// ****************************************
	// Expectations and helpers
	// ****************************************
	// Status word with the registered target bit masked out
	function automatic logic [15:0] exp_st(input logic [6:0] code);
		logic m12;
		logic m13;
		m12 = (op_mode inside {8'h01, 8'h03, 8'h06, 8'h07}) & mode_flag_a;
		m13 = (op_mode inside {8'h01, 8'h03, 8'h06}) & mode_flag_b;
		return {2'b00, m13, m12, int_limit, 3'b010, warning, code | {2'b00, hv_present, 4'h0}};
	endfunction
	// Mode outputs, halt first, then point to point, home, path, speed; point to point and speed bit 6 down to 4, home and path bit 4
	function automatic logic [15:0] exp_mode(input logic [15:0] c);
		return {7'h00, c[8], (op_mode == 8'h01) ? c[6:4] : 3'h0, op_mode == 8'h06 && c[4],
			op_mode == 8'h07 && c[4], (op_mode == 8'h02) ? c[6:4] : 3'h0};
	endfunction
	// Power stage outputs: power, drive enable, quick stop, fault reaction
	function automatic logic [15:0] exp_pwr(input logic [6:0] code);
		return {12'h000, code inside {7'h23, 7'h27, 7'h07, 7'h0F},
			code inside {7'h27, 7'h07, 7'h0F}, code == 7'h07, code == 7'h0F};
	endfunction
	// Random word, fault reset and reserved bits cleared, then fixed bits set
	function automatic logic [15:0] rnd(input logic [15:0] keep, input logic [15:0] set);
		return (16'($urandom) & keep & 16'hF97F) | set;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Write lands at one edge, state moves at the next
	task automatic step(input logic [15:0] c);
		i_dcsw_host_model.send(c, $urandom % 3);
		tick(1);
	endtask
	task automatic st(input logic [6:0] code);
		chk(status_word & 16'hFBFF, exp_st(code));
		// State decode must also reach the power stage outputs
		chk({12'h000, power_on, drive_enable, qstop_run, fault_react_run}, exp_pwr(code));
	endtask
	task automatic go_open;
		step(16'h0006);
		step(16'h000F);
		step(16'h000F);
	endtask
	task automatic close_out;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 5000)
		begin
			fails = fails + 1;
			close_out();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{init_done, fault_present, fault_nonfatal, fault_react_done, qstop_done} = '0;
		{hv_present, warning, target_reached, target_changed, at_rest, int_limit} = '0;
		{mode_flag_a, mode_flag_b, qstop_option, op_mode} = '0;
		clk_en = 1'b1;
		void'($urandom(32'h7378));
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(status_word, 16'h0200);
		@(posedge sys_clk);
		rst <= 1'b0;
		init_done <= 1'b1;
		tick(2);
		st(7'h40);
		for (i = 0; i < 7; i++)
		begin
			step(walk_w[i]);
			st(walk_s[i]);
		end
		// Option 0: completed quick stop leaves to switch on disabled
		@(posedge sys_clk);
		qstop_done <= 1'b1;
		tick(2);
		st(7'h40);
		for (i = 5; i <= 8; i++)
		begin
			@(posedge sys_clk);
			qstop_done <= 1'b0;
			at_rest <= 1'b0;
			qstop_option <= 16'(i);
			go_open();
			step(rnd(16'hFFF9, 16'h0002));
			st(7'h07);
			@(posedge sys_clk);
			at_rest <= 1'b1;
			qstop_done <= 1'b1;
			tick(2);
			chk(status_word & 16'h0400, 16'h0400);
			st(7'h07);
			step(16'h000F);
			st(7'h27);
		end
		for (i = 0; i < 3; i++)
		begin
			step(rnd(16'hFFF8, 16'h0006));
			st(7'h21);
			go_open();
			step(rnd(16'hFFFD, 16'h0000));
			st(7'h40);
			go_open();
		end
		// Target flag: set-point, new target, halt at rest
		@(posedge sys_clk);
		qstop_done <= 1'b0;
		target_reached <= 1'b1;
		tick(2);
		chk(status_word & 16'h0400, 16'h0400);
		@(posedge sys_clk);
		target_reached <= 1'b0;
		target_changed <= 1'b1;
		tick(2);
		chk(status_word & 16'h0400, 16'h0000);
		@(posedge sys_clk);
		target_changed <= 1'b0;
		step(16'h010F);
		tick(1);
		chk(status_word & 16'h0400, 16'h0400);
		@(posedge sys_clk);
		at_rest <= 1'b0;
		tick(2);
		chk(status_word & 16'h0400, 16'h0000);
		// Live inputs and mode bits at random, state must hold
		for (i = 0; i < 40; i++)
		begin
			@(posedge sys_clk);
			{hv_present, warning, int_limit, mode_flag_a, mode_flag_b} <= 5'($urandom);
			op_mode <= modes[$urandom % 6];
			w = rnd(16'hFFFF, 16'h000F);
			step(w);
			st(7'h27);
			chk(cmd_rdata, w);
			chk({7'h00, halt_req, ptp_relative, ptp_change_now, ptp_new_target, home_start,
				path_enable, spd_use_ref, spd_ramp_unlock, spd_ramp_enable}, exp_mode(w));
		end
		// Frozen clock enable drops the write
		@(posedge sys_clk);
		clk_en <= 1'b0;
		step(16'h0006);
		chk(cmd_rdata, w);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		fault_nonfatal <= 1'b1;
		fault_present <= 1'b1;
		tick(2);
		st(7'h0F);
		@(posedge sys_clk);
		fault_react_done <= 1'b1;
		tick(2);
		st(7'h08);
		step(16'h0080);
		st(7'h08);
		step(16'h0000);
		@(posedge sys_clk);
		fault_present <= 1'b0;
		fault_react_done <= 1'b0;
		step(rnd(16'hFFFF, 16'h0080));
		st(7'h40);
		step(16'h0000);
		close_out();
	end
endmodule
